// ===== src/sgs_defs.svh
// offsets, field positions, reset values and codes of the group switch block
// Notes on behaviour
// R1: mode setting: fixed 1-4, inputs, remote; default 1
// R2: inputs mode: sole true input picks group
// R3: inputs mode: several true inputs, no change
// R4: no input true: keep last active group
// R5: input assignments writable only in inputs mode
// R6: led ack signal rising acknowledges all LEDs
// R7: relay ack signal rising acknowledges all relays
// R8: remote ack signal rising resets remote image
// R9: lock signal true rejects every parameter write
// R10: display scaling setting; default per unit
// R11: remote mode: remote command picks group
`ifndef SGS_DEFS_SVH
`define SGS_DEFS_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define SGS_CTRL_OFS     8'h00
`define SGS_GRP_OFS      8'h04
`define SGS_ACK_OFS      8'h08
`define SGS_STAT_OFS     8'h0c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SGS_MODE_LSB     0
`define SGS_SCALE_LSB    4
`define SGS_SEL_W        5
`define SGS_SEL_STRIDE   8
`define SGS_STAT_LOCK    4
`define SGS_STAT_CONF    5

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define SGS_CTRL_RST     32'h0000_0000
`define SGS_SEL_RST      5'h00
`define SGS_RESP_OKAY    2'h0
`define SGS_RESP_SLVERR  2'h2
`define SGS_RESP_DECERR  2'h3

`endif

// ===== src/sgs_pkg.sv
// types shared by the group switch block
package sgs_pkg;

  typedef enum logic [2:0] {
    SGS_FIXED_ONE,
    SGS_FIXED_TWO,
    SGS_FIXED_THREE,
    SGS_FIXED_FOUR,
    SGS_SELECT_BY_INPUTS,
    SGS_SELECT_BY_REMOTE
  } sgs_mode_e;

  typedef enum logic [1:0] {
    SGS_SCALE_PER_UNIT,
    SGS_SCALE_PRIMARY,
    SGS_SCALE_SECONDARY
  } sgs_scale_e;

endpackage

// ===== src/sgs_pick.sv
// picks one assignable signal by index and flags its rising edge
`include "sgs_defs.svh"
module sgs_pick #(
  parameter int N_SIG = 16
) (
  input  wire logic                  aclk,    // system clock
  input  wire logic                  aresetn, // sync reset, active low
  input  wire logic                  ce,      // clock enable
  input  wire logic [N_SIG-1:0]      sig,     // synchronised signals
  input  wire logic [`SGS_SEL_W-1:0] sel,     // 0 = unassigned
  output logic                       level,   // selected signal state
  output logic                       rise     // level became true
);

  logic [31:0] sig_ext;
  logic        prev;

  // index 0 reads a constant zero so an unassigned slot never fires
  assign sig_ext = {{(31-N_SIG){1'b0}}, sig, 1'b0};
  assign level   = sig_ext[sel];
  assign rise    = level & ~prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= 1'b0;
    end else if (ce) begin
      prev <= level;
    end
  end

endmodule

// ===== src/sgs_top.sv
// setting group switch, external acknowledge and settings lock
`include "sgs_defs.svh"
module sgs_top #(
  parameter int AW    = 8,  // axi address width
  parameter int N_SIG = 16  // signals on the assignment list
) (
  input  wire logic             aclk,          // system clock
  input  wire logic             aresetn,       // sync reset, active low
  input  wire logic             ce,            // clock enable
  input  wire logic [N_SIG-1:0] sig_in,        // assignable pin signals
  input  wire logic [1:0]       remote_group,  // commanded group, 0..3
  input  wire logic             remote_valid,  // command strobe
  output logic [1:0]            active_group,  // active group, 0..3
  output logic [3:0]            group_onehot,  // active group, one-hot
  output logic                  indicator_ack, // acknowledge LEDs
  output logic                  relay_ack,     // acknowledge relays
  output logic                  remote_ack,    // reset remote image
  output logic                  settings_locked, // lock in force
  output logic [1:0]            scaling_sel,   // display scaling
  input  wire logic [AW-1:0]    s_axi_awaddr,  // write address
  input  wire logic             s_axi_awvalid, // write address valid
  output logic                  s_axi_awready, // write address ready
  input  wire logic [31:0]      s_axi_wdata,   // write data
  input  wire logic [3:0]       s_axi_wstrb,   // byte strobes
  input  wire logic             s_axi_wvalid,  // write data valid
  output logic                  s_axi_wready,  // write data ready
  output logic [1:0]            s_axi_bresp,   // write response
  output logic                  s_axi_bvalid,  // write response valid
  input  wire logic             s_axi_bready,  // write response ready
  input  wire logic [AW-1:0]    s_axi_araddr,  // read address
  input  wire logic             s_axi_arvalid, // read address valid
  output logic                  s_axi_arready, // read address ready
  output logic [31:0]           s_axi_rdata,   // read data
  output logic [1:0]            s_axi_rresp,   // read response
  output logic                  s_axi_rvalid,  // read data valid
  input  wire logic             s_axi_rready   // read data ready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int NPICK = 8; // 4 group inputs, led, relay, remote, lock

  sgs_pkg::sgs_mode_e   mode_q;
  sgs_pkg::sgs_scale_e  scale_q;
  logic [`SGS_SEL_W-1:0] pick_sel [NPICK];
  logic [NPICK-1:0]     pick_lvl;
  logic [NPICK-1:0]     pick_rise;
  logic [N_SIG-1:0]     sig_meta;
  logic [N_SIG-1:0]     sig_sync;
  logic [3:0]           grp_lvl;
  logic                 grp_single;
  logic [1:0]           grp_enc;
  logic                 lock_q;
  logic                 aw_held;
  logic                 w_held;
  logic [AW-1:0]        aw_addr_q;
  logic [31:0]          w_data_q;
  logic [3:0]           w_strb_q;
  logic                 do_write;
  logic [31:0]          wmask;
  logic [31:0]          ctrl_word;
  logic [31:0]          grp_word;
  logic [31:0]          ack_word;
  logic [31:0]          stat_word;
  logic [31:0]          next_ctrl;
  logic [31:0]          next_grp;
  logic [31:0]          next_ack;
  logic [2:0]           next_mode;
  logic [1:0]           next_scale;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sig_meta <= '0;
      sig_sync <= '0;
    end else if (ce) begin
      sig_meta <= sig_in;
      sig_sync <= sig_meta;
    end
  end

  // ----------------------------------------------------------------
  // assignment pickers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NPICK; i++) begin : g_pick
    sgs_pick #(
      .N_SIG (N_SIG)
    ) u_pick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .sig     (sig_sync),
      .sel     (pick_sel[i]),
      .level   (pick_lvl[i]),
      .rise    (pick_rise[i])
    );
  end

  assign grp_lvl = pick_lvl[3:0];
  always_comb begin
    grp_enc = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (grp_lvl[k]) begin
        grp_enc = 2'(k);
      end
    end
  end

  // exactly one of the four inputs true
  assign grp_single = (grp_lvl != 4'h0) &&
                      ((grp_lvl & (grp_lvl - 4'h1)) == 4'h0);

  // ----------------------------------------------------------------
  // active group selection
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_group <= 2'h0;                          // [R1]
    end else if (ce) begin
      unique case (mode_q)
        sgs_pkg::SGS_FIXED_ONE:   active_group <= 2'h0; // [R1]
        sgs_pkg::SGS_FIXED_TWO:   active_group <= 2'h1; // [R1]
        sgs_pkg::SGS_FIXED_THREE: active_group <= 2'h2; // [R1]
        sgs_pkg::SGS_FIXED_FOUR:  active_group <= 2'h3; // [R1]
        sgs_pkg::SGS_SELECT_BY_INPUTS: begin
          // conflict or all-false both hold the last group
          if (grp_single) begin                      // [R2] [R3] [R4]
            active_group <= grp_enc;
          end
        end
        sgs_pkg::SGS_SELECT_BY_REMOTE: begin
          if (remote_valid) begin                    // [R11]
            active_group <= remote_group;
          end
        end
        default: active_group <= active_group;
      endcase
    end
  end

  always_comb begin
    group_onehot = 4'h0;
    group_onehot[active_group] = 1'b1;
  end

  // ----------------------------------------------------------------
  // acknowledge pulses and lock
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      indicator_ack <= 1'b0;
      relay_ack     <= 1'b0;
      remote_ack    <= 1'b0;
      lock_q        <= 1'b0;
    end else if (ce) begin
      indicator_ack <= pick_rise[4];                 // [R6]
      relay_ack     <= pick_rise[5];                 // [R7]
      remote_ack    <= pick_rise[6];                 // [R8]
      lock_q        <= pick_lvl[7];                  // [R9]
    end
  end

  assign settings_locked = lock_q;
  assign scaling_sel     = scale_q;                  // [R10]

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{w_strb_q[b]}};
    end
  end

  always_comb begin
    ctrl_word = 32'h0;
    ctrl_word[`SGS_MODE_LSB +: 3]  = mode_q;
    ctrl_word[`SGS_SCALE_LSB +: 2] = scale_q;
    grp_word  = 32'h0;
    ack_word  = 32'h0;
    for (int g = 0; g < 4; g++) begin
      grp_word[`SGS_SEL_STRIDE*g +: `SGS_SEL_W] = pick_sel[g];
      ack_word[`SGS_SEL_STRIDE*g +: `SGS_SEL_W] = pick_sel[g+4];
    end
    stat_word = 32'h0;
    stat_word[1:0]            = active_group;
    stat_word[`SGS_STAT_LOCK] = lock_q;
    stat_word[`SGS_STAT_CONF] = !grp_single && (grp_lvl != 4'h0);
    next_ctrl  = (ctrl_word & ~wmask) | (w_data_q & wmask);
    next_grp   = (grp_word & ~wmask) | (w_data_q & wmask);
    next_ack   = (ack_word & ~wmask) | (w_data_q & wmask);
    next_mode  = next_ctrl[`SGS_MODE_LSB +: 3];
    next_scale = next_ctrl[`SGS_SCALE_LSB +: 2];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // register update and write answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q       <= sgs_pkg::sgs_mode_e'(`SGS_CTRL_RST >> `SGS_MODE_LSB);
      scale_q      <= sgs_pkg::SGS_SCALE_PER_UNIT;   // [R10]
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SGS_RESP_OKAY;
      for (int i = 0; i < NPICK; i++) begin
        pick_sel[i] <= `SGS_SEL_RST;
      end
    end else if (ce) begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `SGS_RESP_OKAY;
        if ({aw_addr_q[AW-1:2], 2'b00} > AW'(`SGS_STAT_OFS)) begin
          s_axi_bresp <= `SGS_RESP_DECERR;
        end else if (lock_q) begin
          s_axi_bresp <= `SGS_RESP_SLVERR;           // [R9]
        end else begin
          unique case ({aw_addr_q[AW-1:2], 2'b00})
            AW'(`SGS_CTRL_OFS): begin
              // illegal mode or scaling codes leave both fields untouched
              if (next_mode > 3'(sgs_pkg::SGS_SELECT_BY_REMOTE) ||
                  next_scale == 2'h3) begin
                s_axi_bresp <= `SGS_RESP_SLVERR;
              end else begin
                mode_q  <= sgs_pkg::sgs_mode_e'(next_mode);  // [R1]
                scale_q <= sgs_pkg::sgs_scale_e'(next_scale); // [R10]
              end
            end
            AW'(`SGS_GRP_OFS): begin
              if (mode_q == sgs_pkg::SGS_SELECT_BY_INPUTS) begin // [R5]
                for (int g = 0; g < 4; g++) begin
                  pick_sel[g] <= next_grp[`SGS_SEL_STRIDE*g +: `SGS_SEL_W];
                end
              end else begin
                s_axi_bresp <= `SGS_RESP_SLVERR;     // [R5]
              end
            end
            AW'(`SGS_ACK_OFS): begin
              for (int g = 0; g < 4; g++) begin
                pick_sel[g+4] <= next_ack[`SGS_SEL_STRIDE*g +: `SGS_SEL_W];
              end
            end
            default: s_axi_bresp <= `SGS_RESP_SLVERR; // status is read-only
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `SGS_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SGS_RESP_OKAY;
        unique case ({s_axi_araddr[AW-1:2], 2'b00})
          AW'(`SGS_CTRL_OFS): s_axi_rdata <= ctrl_word;
          // group input assignments are hidden outside inputs mode
          AW'(`SGS_GRP_OFS):
            s_axi_rdata <= (mode_q == sgs_pkg::SGS_SELECT_BY_INPUTS) ?
                           grp_word : 32'h0;         // [R5]
          AW'(`SGS_ACK_OFS):  s_axi_rdata <= ack_word;
          AW'(`SGS_STAT_OFS): s_axi_rdata <= stat_word;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SGS_RESP_DECERR;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_inputs_mode;
    ce && mode_q == sgs_pkg::SGS_SELECT_BY_INPUTS;
  endsequence
  sequence s_led_event;
    ce && pick_rise[4];
  endsequence

  a_fixed_group: assert property (
    ce && mode_q == sgs_pkg::SGS_FIXED_THREE |=> active_group == 2'h2
  ) else $error("fixed mode did not force its group"); // [R1]
  a_sole_input: assert property (
    s_inputs_mode and grp_lvl == 4'h4 |=> active_group == 2'h2
  ) else $error("sole group input did not select group"); // [R2]
  a_input_conflict: assert property (
    s_inputs_mode and $countones(grp_lvl) > 1 |=> $stable(active_group)
  ) else $error("group changed during input conflict"); // [R3]
  a_inputs_idle: assert property (
    s_inputs_mode and grp_lvl == 4'h0 |=> $stable(active_group)
  ) else $error("group changed with no input true"); // [R4]
  a_assign_gate: assert property (
    ce && do_write && mode_q != sgs_pkg::SGS_SELECT_BY_INPUTS &&
    {aw_addr_q[AW-1:2], 2'b00} == AW'(`SGS_GRP_OFS)
    |=> $stable(pick_sel[0]) && s_axi_bresp != `SGS_RESP_OKAY
  ) else $error("assignment written outside inputs mode"); // [R5]
  a_led_ack: assert property (
    s_led_event ##1 ce |-> indicator_ack ##1 !indicator_ack
  ) else $error("led acknowledge not a single pulse"); // [R6]
  a_relay_ack: assert property (
    ce && !pick_rise[5] |=> !relay_ack
  ) else $error("relay acknowledge without a rising edge"); // [R7]
  a_remote_ack: assert property (
    ce && pick_rise[6] |=> remote_ack
  ) else $error("remote image reset missed"); // [R8]
  a_lock_reject: assert property (
    ce && do_write && lock_q |=>
      s_axi_bvalid && s_axi_bresp != `SGS_RESP_OKAY &&
      $stable(mode_q) && $stable(scale_q)
  ) else $error("write accepted while settings locked"); // [R9]
  a_scaling_reset: assert property (
    $rose(aresetn) |-> scaling_sel == 2'h0
  ) else $error("scaling not per unit after reset"); // [R10]
  a_remote_group: assert property (
    ce && mode_q == sgs_pkg::SGS_SELECT_BY_REMOTE && remote_valid
    |=> active_group == $past(remote_group)
  ) else $error("remote command not applied"); // [R11]

endmodule

// ===== tb/sgs_far_model.sv
// far side model: digital input pins and the remote group command link
module sgs_far_model (
  input  wire logic        aclk,         // system clock
  input  wire logic [15:0] pin_req,      // wanted pin levels
  input  wire logic [1:0]  cmd_group,    // group to command
  input  wire logic        cmd_go,       // send one command
  output logic      [15:0] sig_in,       // pin levels to the block
  output logic      [1:0]  remote_group, // commanded group
  output logic             remote_valid  // command strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sig_in       = 16'h0;
    remote_group = 2'h0;
    remote_valid = 1'h0;
  end

  // ----------------------------------------------------------------
  // pins follow requests; commands are one strobe with the group
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    sig_in       <= pin_req;
    remote_valid <= cmd_go;
    // idle group lines toggle so a stale value is never mistaken
    remote_group <= cmd_go ? cmd_group : ~remote_group;
  end
endmodule

// ===== tb/sgs_top_test.sv
// self-checking bench for the setting group switch block
`include "sgs_defs.svh"
module sgs_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        aclk, aresetn, cmd_go, remote_valid;
  logic [15:0] pin_req, sig_in;
  logic [1:0]  cmd_group, remote_group, active_group, scaling_sel;
  logic [3:0]  group_onehot;
  logic        indicator_ack, relay_ack, remote_ack, settings_locked;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  int          n_mismatch, checks_done;
  int          ack_cnt [3];
  int          base [3];

  sgs_far_model sgs_far_model_i (
    .aclk(aclk), .pin_req(pin_req), .cmd_group(cmd_group), .cmd_go(cmd_go),
    .sig_in(sig_in), .remote_group(remote_group),
    .remote_valid(remote_valid));

  sgs_top sgs_top_i (
    .aclk(aclk), .aresetn(aresetn), .ce(1'h1), .sig_in(sig_in),
    .remote_group(remote_group), .remote_valid(remote_valid),
    .active_group(active_group), .group_onehot(group_onehot),
    .indicator_ack(indicator_ack), .relay_ack(relay_ack),
    .remote_ack(remote_ack), .settings_locked(settings_locked),
    .scaling_sel(scaling_sel),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (indicator_ack === 1'h1) ack_cnt[0]++;
    if (relay_ack === 1'h1) ack_cnt[1]++;
    if (remote_ack === 1'h1) ack_cnt[2]++;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic void chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'h1) awvalid <= 1'h0;
      if (wvalid && wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 40);
    bready <= 1'h0;
    if (n >= 40) begin
      n_mismatch++;
      $display("wrong value at %0t: write answer timed out", $time);
    end
    chk(bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 40);
    rready <= 1'h0;
    if (n >= 40) begin
      n_mismatch++;
      $display("wrong value at %0t: read answer timed out", $time);
    end
    chk(rdata, ed);
    chk(rresp, er);
  endtask

  task automatic pins(input logic [15:0] p);
    @(posedge aclk);
    pin_req <= p;
    repeat (8) @(posedge aclk);
  endtask

  // waits a bounded time for the group, then compares
  task automatic expect_group(input logic [1:0] g);
    int n;
    n = 0;
    while (active_group !== g && n < 12) begin
      @(posedge aclk);
      n++;
    end
    chk(active_group, g);
    chk(group_onehot, 4'h1 << g);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'h0; pin_req = 16'h0; cmd_group = 2'h0; cmd_go = 1'h0;
    awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0;
    awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0;
    arvalid = 1'h0; rready = 1'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    expect_group(2'h0);
    chk(scaling_sel, 2'h0);
    rd(`SGS_CTRL_OFS, `SGS_CTRL_RST, `SGS_RESP_OKAY);
    wr(`SGS_GRP_OFS, 32'h1, `SGS_RESP_SLVERR);
    rd(`SGS_GRP_OFS, 32'h0, `SGS_RESP_OKAY);
    for (int m = 3; m >= 0; m--) begin
      wr(`SGS_CTRL_OFS, m, `SGS_RESP_OKAY);
      expect_group(m[1:0]);
    end
    for (int s = 0; s < 3; s++) begin
      wr(`SGS_CTRL_OFS, s << 4, `SGS_RESP_OKAY);
      chk(scaling_sel, s[1:0]);
    end
    wr(`SGS_CTRL_OFS, 32'h30, `SGS_RESP_SLVERR);
    wr(`SGS_CTRL_OFS, 32'h6, `SGS_RESP_SLVERR);
    rd(`SGS_CTRL_OFS, 32'h20, `SGS_RESP_OKAY);
    // inputs mode: group g listens to sig_in[g]
    wr(`SGS_CTRL_OFS, 32'h4, `SGS_RESP_OKAY);
    wr(`SGS_GRP_OFS, 32'h0403_0201, `SGS_RESP_OKAY);
    rd(`SGS_GRP_OFS, 32'h0403_0201, `SGS_RESP_OKAY);
    pins(16'h4);
    expect_group(2'h2);
    pins(16'h0);
    expect_group(2'h2);
    pins(16'h3);
    expect_group(2'h2);
    pins(16'h2);
    expect_group(2'h1);
    pins(16'hf);
    expect_group(2'h1);
    rd(`SGS_STAT_OFS, 32'h21, `SGS_RESP_OKAY);
    // remote mode ignores the group inputs
    wr(`SGS_CTRL_OFS, 32'h5, `SGS_RESP_OKAY);
    pins(16'h8);
    expect_group(2'h1);
    rd(`SGS_GRP_OFS, 32'h0, `SGS_RESP_OKAY);
    @(posedge aclk);
    cmd_group <= 2'h3;
    cmd_go    <= 1'h1;
    @(posedge aclk);
    cmd_go    <= 1'h0;
    expect_group(2'h3);
    pins(16'h0);
    // led, relay, remote image and lock on sig_in[4..7]
    wr(`SGS_ACK_OFS, 32'h0807_0605, `SGS_RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      base = ack_cnt;
      pins(16'h10 << k);
      pins(16'h0);
      for (int j = 0; j < 3; j++) begin
        chk(ack_cnt[j] - base[j], (j == k));
      end
    end
    pins(16'h80);
    chk(settings_locked, 1'h1);
    wr(`SGS_CTRL_OFS, 32'h1, `SGS_RESP_SLVERR);
    wr(`SGS_ACK_OFS, 32'h0, `SGS_RESP_SLVERR);
    rd(`SGS_CTRL_OFS, 32'h5, `SGS_RESP_OKAY);
    rd(`SGS_ACK_OFS, 32'h0807_0605, `SGS_RESP_OKAY);
    rd(`SGS_STAT_OFS, 32'h13, `SGS_RESP_OKAY);
    pins(16'h0);
    chk(settings_locked, 1'h0);
    wr(`SGS_CTRL_OFS, 32'h0, `SGS_RESP_OKAY);
    expect_group(2'h0);
    wr(`SGS_STAT_OFS, 32'h0, `SGS_RESP_SLVERR);
    wr(8'h10, 32'h0, `SGS_RESP_DECERR);
    rd(8'h10, 32'h0, `SGS_RESP_DECERR);
    tally_and_finish();
  end

  // a run still going after 6000 cycles ends as a failure
  initial begin
    repeat (6000) @(posedge aclk);
    n_mismatch++;
    $display("wrong value at %0t: run timed out", $time);
    tally_and_finish();
  end
endmodule
